// >>> rtl/rfpp_top.sv
// Purpose: FIFO data path, packet framing and demod back end
// Assumes: SPI mode 0, host frames each command within one chip select
// Notes: SPI logic runs on the host clock; bytes cross by toggles
`timescale 1ns/1ns
module rfpp_top (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // SPI link
  input wire logic i_spi_sck,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sdi,
  output logic o_spi_sdo,
  output logic o_spi_sdo_oe,
  // Configuration
  input wire logic i_direct_mode,
  input wire logic i_ph_en,
  input wire logic i_async_demod,
  input wire logic [1:0] i_idle_sel,
  input wire logic [1:0] i_tx_src,
  input wire logic [6:0] i_pkt_len,
  input wire logic [3:0] i_pre_bytes,
  input wire logic [15:0] i_sync_word,
  input wire logic [4:0] i_pre_thresh,
  input wire logic [1:0] i_irq_en,
  // Commands
  input wire logic i_start_tx,
  input wire logic i_start_rx,
  input wire logic i_status_rd,
  // Radio pins
  input wire logic i_demod_raw,
  input wire logic i_direct_tx_bit,
  output logic o_tx_bit,
  output logic o_cw_en,
  output logic o_rx_bit_tap,
  output logic o_rx_clk,
  // Status
  output logic [1:0] o_mode,
  output logic [1:0] o_idle_state,
  output logic o_bcr_lock,
  output logic [7:0] o_freq_err,
  output logic o_crc_err,
  output logic o_tx_done_event,
  output logic o_rx_done_event,
  output logic [1:0] o_int_status,
  output logic o_radio_irq_n,
  output logic [6:0] o_tx_level,
  output logic [6:0] o_rx_level
);
  localparam int AW = rfpp_pkg::FIFO_AW;
  localparam logic [7:0] BIT_C = 8'(rfpp_pkg::BIT_CYC);

  logic [1:0] rst_q;
  logic rst_n;
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // SPI domain: chip select high clears the frame state
  logic [2:0] sbit_q;
  logic [6:0] sin_q;
  logic sfirst_q;
  logic [7:0] scmd_q;
  logic [7:0] wr_byte_q;
  logic wr_tgl_q;
  logic [7:0] sout_q;
  logic pop_tgl_q;
  logic [7:0] rx_head_q;

  always_ff @(posedge i_spi_sck or posedge i_spi_cs_n)
  begin
    if (i_spi_cs_n)
    begin
      sbit_q <= 3'h0;
      sin_q <= 7'h00;
      sfirst_q <= 1'b1;
      scmd_q <= 8'h00;
    end
    else
    begin
      sin_q <= {sin_q[5:0], i_spi_sdi};
      sbit_q <= sbit_q + 3'h1;
      if (sbit_q == 3'h7)
      begin
        sfirst_q <= 1'b0;
        if (sfirst_q)
          scmd_q <= {sin_q, i_spi_sdi};
      end
    end
  end

  // Byte handed over by toggle; it stays put for eight SPI clocks
  always_ff @(posedge i_spi_sck or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_byte_q <= 8'h00;
      wr_tgl_q <= 1'b0;
    end
    else if (!i_spi_cs_n && sbit_q == 3'h7 && !sfirst_q &&
             scmd_q == rfpp_pkg::CMD_TX_WRITE)
    begin
      wr_byte_q <= {sin_q, i_spi_sdi};
      wr_tgl_q <= ~wr_tgl_q;
    end
  end

  // Output shifts on the falling edge so the host samples on rising
  always_ff @(negedge i_spi_sck or posedge i_spi_cs_n)
  begin
    if (i_spi_cs_n)
      sout_q <= 8'h00;
    else if (sbit_q == 3'h0 && !sfirst_q &&
             scmd_q == rfpp_pkg::CMD_RX_READ)
      sout_q <= rx_head_q;
    else
      sout_q <= {sout_q[6:0], 1'b0};
  end

  always_ff @(posedge i_spi_sck or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pop_tgl_q <= 1'b0;
    else if (!i_spi_cs_n && sbit_q == 3'h0 && !sfirst_q &&
             scmd_q == rfpp_pkg::CMD_RX_READ)
      pop_tgl_q <= ~pop_tgl_q;
  end

  assign o_spi_sdo = sout_q[7];
  assign o_spi_sdo_oe = !i_spi_cs_n;

  // Synchronisers for toggles and pins
  logic [2:0] wr_s_q;
  logic [2:0] pop_s_q;
  logic [1:0] raw_s_q;
  logic [1:0] dtx_s_q;
  logic wr_ev;
  logic pop_ev;
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_s_q <= 3'h0;
      pop_s_q <= 3'h0;
      raw_s_q <= 2'h0;
      dtx_s_q <= 2'h0;
    end
    else if (i_ce)
    begin
      wr_s_q <= {wr_s_q[1:0], wr_tgl_q};
      pop_s_q <= {pop_s_q[1:0], pop_tgl_q};
      raw_s_q <= {raw_s_q[0], i_demod_raw};
      dtx_s_q <= {dtx_s_q[0], i_direct_tx_bit};
    end
  end
  assign wr_ev = wr_s_q[2] ^ wr_s_q[1];
  assign pop_ev = pop_s_q[2] ^ pop_s_q[1];

  // FIFOs; direct mode locks them out
  logic [AW:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic tx_full, tx_empty, rx_full, rx_empty;
  logic [7:0] tx_rdata, rx_rdata;
  logic tx_pop_q, rx_push_q;
  logic [7:0] rx_wdata_q;
  assign tx_full = (tx_wp_q ^ tx_rp_q) == {1'b1, {AW{1'b0}}};
  assign tx_empty = tx_wp_q == tx_rp_q;
  assign rx_full = (rx_wp_q ^ rx_rp_q) == {1'b1, {AW{1'b0}}};
  assign rx_empty = rx_wp_q == rx_rp_q;

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_head_q <= 8'h00;
    end
    else if (i_ce)
    begin
      if (wr_ev && !tx_full && !i_direct_mode)
        tx_wp_q <= tx_wp_q + 1'b1;
      if (tx_pop_q && !tx_empty)
        tx_rp_q <= tx_rp_q + 1'b1;
      if (rx_push_q && !rx_full)
        rx_wp_q <= rx_wp_q + 1'b1;
      if (pop_ev && !rx_empty && !i_direct_mode)
        rx_rp_q <= rx_rp_q + 1'b1;
      rx_head_q <= rx_empty ? 8'h00 : rx_rdata;
    end
  end
  assign o_tx_level = 7'(tx_wp_q - tx_rp_q);
  assign o_rx_level = 7'(rx_wp_q - rx_rp_q);

  rfpp_mem u_tx_mem (
    .i_clk(i_core_clk),
    .i_ce(i_ce),
    .i_we(wr_ev && !tx_full && !i_direct_mode),
    .i_waddr(tx_wp_q[AW-1:0]),
    .i_wdata(wr_byte_q),
    .i_raddr(tx_rp_q[AW-1:0]),
    .o_rdata(tx_rdata)
  );

  rfpp_mem u_rx_mem (
    .i_clk(i_core_clk),
    .i_ce(i_ce),
    .i_we(rx_push_q && !rx_full),
    .i_waddr(rx_wp_q[AW-1:0]),
    .i_wdata(rx_wdata_q),
    .i_raddr(rx_rp_q[AW-1:0]),
    .o_rdata(rx_rdata)
  );

  // Demodulator back end
  logic dg_q, prev_q, lock_q;
  logic [3:0] dg_cnt_q;
  logic [7:0] phase_q, per_q, ferr_q;
  logic [2:0] trans_q;
  logic smp_q, bit_q;
  logic demod, edge_d;
  assign demod = i_async_demod ? dg_q : raw_s_q[1];
  assign edge_d = demod != prev_q;

  // Deglitch costs DGL_CYC cycles of latency on each edge
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dg_q <= 1'b0;
      dg_cnt_q <= 4'h0;
    end
    else if (i_ce)
    begin
      if (raw_s_q[1] == dg_q)
        dg_cnt_q <= 4'h0;
      else if (dg_cnt_q == 4'(rfpp_pkg::DGL_CYC - 1))
      begin
        dg_q <= raw_s_q[1];
        dg_cnt_q <= 4'h0;
      end
      else
        dg_cnt_q <= dg_cnt_q + 4'h1;
    end
  end

  rfpp_pkg::rfpp_state_e st_q;
  logic rx_on;
  assign rx_on = st_q == rfpp_pkg::ST_RX_HUNT ||
                 st_q == rfpp_pkg::ST_RX_DATA;

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q <= 1'b0;
      phase_q <= 8'h00;
      per_q <= 8'h00;
      ferr_q <= 8'h00;
      trans_q <= 3'h0;
      lock_q <= 1'b0;
      smp_q <= 1'b0;
      bit_q <= 1'b0;
    end
    else if (i_ce)
    begin
      prev_q <= demod;
      smp_q <= 1'b0;
      if (!rx_on)
      begin
        trans_q <= 3'h0;
        lock_q <= 1'b0;
      end
      else if (i_async_demod)
        lock_q <= 1'b1;
      if (edge_d)
      begin
        phase_q <= BIT_C >> 1;
        per_q <= 8'h01;
        if (rx_on && !lock_q && !i_async_demod)
        begin
          if (per_q >= (BIT_C >> 1) && per_q <= BIT_C + (BIT_C >> 1))
          begin
            ferr_q <= per_q - BIT_C;
            trans_q <= trans_q + 3'h1;
            if (trans_q == 3'(rfpp_pkg::LOCK_TRANS - 1))
              lock_q <= 1'b1;
          end
          else
            trans_q <= 3'h0;
        end
      end
      else
      begin
        if (per_q != 8'hFF)
          per_q <= per_q + 8'h1;
        if (phase_q == 8'h00)
        begin
          phase_q <= BIT_C - 8'h1;
          smp_q <= 1'b1;
          bit_q <= demod;
        end
        else
          phase_q <= phase_q - 8'h1;
      end
    end
  end
  assign o_rx_bit_tap = bit_q;
  assign o_rx_clk = smp_q;
  assign o_bcr_lock = lock_q;
  assign o_freq_err = ferr_q;

  // Transmit bit timer and PRBS
  logic [7:0] btmr_q;
  logic btick;
  logic [8:0] prbs_q;
  logic tx_on;
  assign btick = btmr_q == 8'h00;
  assign tx_on = st_q == rfpp_pkg::ST_TX_PRE || st_q == rfpp_pkg::ST_TX_SYNC
              || st_q == rfpp_pkg::ST_TX_LEN || st_q == rfpp_pkg::ST_TX_DATA
              || st_q == rfpp_pkg::ST_TX_CRC;
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      btmr_q <= 8'h00;
      prbs_q <= rfpp_pkg::PRBS_SEED;
    end
    else if (i_ce)
    begin
      btmr_q <= (btick || !tx_on) ? BIT_C - 8'h1 : btmr_q - 8'h1;
      if (tx_on && btick)
        prbs_q <= {prbs_q[7:0], prbs_q[8] ^ prbs_q[4]};
    end
  end

  // Packet state machine
  logic [7:0] sh_q, cnt_q;
  logic [2:0] nb_q;
  logic [15:0] crc_q, sync_sh_q;
  logic [1:0] fld_q;
  logic [4:0] pre_q;
  logic pre_ok_q, crc_err_q, txd_q, rxd_q;
  logic [7:0] tx_byte, rx_byte;
  logic [1:0] idle_q;
  assign tx_byte = tx_empty ? 8'h00 : tx_rdata;
  assign rx_byte = {sh_q[6:0], bit_q};

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= rfpp_pkg::ST_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 8'h00;
      nb_q <= 3'h0;
      crc_q <= rfpp_pkg::CRC_INIT;
      sync_sh_q <= 16'h0000;
      fld_q <= 2'h0;
      pre_q <= 5'h00;
      pre_ok_q <= 1'b0;
      crc_err_q <= 1'b0;
      txd_q <= 1'b0;
      rxd_q <= 1'b0;
      tx_pop_q <= 1'b0;
      rx_push_q <= 1'b0;
      rx_wdata_q <= 8'h00;
      idle_q <= rfpp_pkg::IDLE_RST;
    end
    else if (i_ce)
    begin
      txd_q <= 1'b0;
      rxd_q <= 1'b0;
      tx_pop_q <= 1'b0;
      rx_push_q <= 1'b0;
      case (st_q)
        rfpp_pkg::ST_IDLE:
        begin
          nb_q <= 3'h0;
          if (i_start_tx && !i_direct_mode && i_ph_en)
          begin
            st_q <= rfpp_pkg::ST_TX_PRE;
            sh_q <= rfpp_pkg::PRE_BYTE;
            cnt_q <= 8'(i_pre_bytes) - 8'h1;
          end
          else if (i_start_tx && !i_direct_mode)
          begin
            st_q <= rfpp_pkg::ST_TX_DATA;
            sh_q <= tx_byte;
            tx_pop_q <= 1'b1;
            cnt_q <= 8'(i_pkt_len) - 8'h1;
          end
          else if (i_start_rx && !i_direct_mode)
          begin
            st_q <= rfpp_pkg::ST_RX_HUNT;
            pre_q <= 5'h00;
            pre_ok_q <= 1'b0;
            sync_sh_q <= 16'h0000;
          end
        end
        rfpp_pkg::ST_TX_PRE, rfpp_pkg::ST_TX_SYNC, rfpp_pkg::ST_TX_LEN,
        rfpp_pkg::ST_TX_DATA, rfpp_pkg::ST_TX_CRC:
        begin
          if (btick)
          begin
            nb_q <= nb_q + 3'h1;
            sh_q <= {sh_q[6:0], 1'b0};
            if (nb_q == 3'h7)
            begin
              case (st_q)
                rfpp_pkg::ST_TX_PRE:
                  if (cnt_q == 8'h00)
                  begin
                    st_q <= rfpp_pkg::ST_TX_SYNC;
                    sh_q <= i_sync_word[15:8];
                    cnt_q <= 8'h01;
                  end
                  else
                  begin
                    sh_q <= rfpp_pkg::PRE_BYTE;
                    cnt_q <= cnt_q - 8'h1;
                  end
                rfpp_pkg::ST_TX_SYNC:
                  if (cnt_q == 8'h01)
                  begin
                    sh_q <= i_sync_word[7:0];
                    cnt_q <= 8'h00;
                  end
                  else
                  begin
                    st_q <= rfpp_pkg::ST_TX_LEN;
                    sh_q <= {1'b0, i_pkt_len};
                    crc_q <= rfpp_pkg::rfpp_crc_byte(rfpp_pkg::CRC_INIT,
                                                     {1'b0, i_pkt_len});
                  end
                rfpp_pkg::ST_TX_LEN:
                begin
                  st_q <= rfpp_pkg::ST_TX_DATA;
                  sh_q <= tx_byte;
                  tx_pop_q <= 1'b1;
                  crc_q <= rfpp_pkg::rfpp_crc_byte(crc_q, tx_byte);
                  cnt_q <= 8'(i_pkt_len) - 8'h1;
                end
                rfpp_pkg::ST_TX_DATA:
                  if (cnt_q != 8'h00)
                  begin
                    sh_q <= tx_byte;
                    tx_pop_q <= 1'b1;
                    crc_q <= rfpp_pkg::rfpp_crc_byte(crc_q, tx_byte);
                    cnt_q <= cnt_q - 8'h1;
                  end
                  else if (i_ph_en)
                  begin
                    st_q <= rfpp_pkg::ST_TX_CRC;
                    sh_q <= crc_q[15:8];
                    cnt_q <= 8'h01;
                  end
                  else
                  begin
                    st_q <= rfpp_pkg::ST_IDLE;
                    idle_q <= i_idle_sel;
                    txd_q <= 1'b1;
                  end
                default:
                  if (cnt_q == 8'h01)
                  begin
                    sh_q <= crc_q[7:0];
                    cnt_q <= 8'h00;
                  end
                  else
                  begin
                    st_q <= rfpp_pkg::ST_IDLE;
                    idle_q <= i_idle_sel;
                    txd_q <= 1'b1;
                  end
              endcase
            end
          end
        end
        rfpp_pkg::ST_RX_HUNT:
        begin
          if (smp_q)
          begin
            sync_sh_q <= {sync_sh_q[14:0], bit_q};
            if (bit_q != sync_sh_q[0] && pre_q != 5'h1F)
              pre_q <= pre_q + 5'h01;
            else if (bit_q == sync_sh_q[0])
              pre_q <= 5'h00;
            if (pre_q >= i_pre_thresh)
              pre_ok_q <= 1'b1;
            if ((pre_ok_q || i_pre_thresh == 5'h00) &&
                {sync_sh_q[14:0], bit_q} == i_sync_word)
            begin
              st_q <= rfpp_pkg::ST_RX_DATA;
              nb_q <= 3'h0;
              fld_q <= i_ph_en ? 2'h0 : 2'h1;
              cnt_q <= 8'(i_pkt_len);
              crc_q <= rfpp_pkg::CRC_INIT;
            end
          end
        end
        default:
        begin
          if (smp_q)
          begin
            sh_q <= rx_byte;
            nb_q <= nb_q + 3'h1;
            if (nb_q == 3'h7)
            begin
              case (fld_q)
                2'h0:
                begin
                  cnt_q <= rx_byte;
                  crc_q <= rfpp_pkg::rfpp_crc_byte(crc_q, rx_byte);
                  fld_q <= rx_byte == 8'h00 ? 2'h2 : 2'h1;
                end
                2'h1:
                begin
                  rx_push_q <= 1'b1;
                  rx_wdata_q <= rx_byte;
                  crc_q <= rfpp_pkg::rfpp_crc_byte(crc_q, rx_byte);
                  cnt_q <= cnt_q - 8'h1;
                  if (cnt_q == 8'h01)
                    fld_q <= 2'h2;
                end
                2'h2:
                begin
                  crc_err_q <= rx_byte != crc_q[15:8];
                  fld_q <= 2'h3;
                end
                default:
                begin
                  crc_err_q <= crc_err_q || rx_byte != crc_q[7:0];
                end
              endcase
              if ((fld_q == 2'h1 && cnt_q == 8'h01 && !i_ph_en) ||
                  fld_q == 2'h3)
              begin
                st_q <= rfpp_pkg::ST_IDLE;
                idle_q <= i_idle_sel;
                rxd_q <= 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  // Transmit data source; direct mode bypasses the FIFO path
  always_comb
  begin
    o_cw_en = 1'b0;
    if (i_direct_mode)
      o_tx_bit = dtx_s_q[1];
    else if (!tx_on)
      o_tx_bit = 1'b0;
    else if (i_tx_src == rfpp_pkg::SRC_PRBS)
      o_tx_bit = prbs_q[8];
    else if (i_tx_src == rfpp_pkg::SRC_CW)
    begin
      o_tx_bit = 1'b0;
      o_cw_en = 1'b1;
    end
    else
      o_tx_bit = sh_q[7];
  end

  always_comb
  begin
    if (i_direct_mode)
      o_mode = rfpp_pkg::MODE_DIRECT;
    else if (tx_on)
      o_mode = rfpp_pkg::MODE_TX;
    else if (rx_on)
      o_mode = rfpp_pkg::MODE_RX;
    else
      o_mode = rfpp_pkg::MODE_IDLE;
  end
  assign o_idle_state = idle_q;
  assign o_crc_err = crc_err_q;
  assign o_tx_done_event = txd_q;
  assign o_rx_done_event = rxd_q;

  // Interrupt status: a new event wins over a read in the same cycle
  logic [1:0] ist_q;
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ist_q <= 2'h0;
    else if (i_ce)
      ist_q <= (ist_q & ~{2{i_status_rd}}) |
               ({rxd_q, txd_q} & i_irq_en);
  end
  assign o_int_status = ist_q;
  assign o_radio_irq_n = ~(|ist_q);
endmodule : rfpp_top

// >>> rtl/rfpp_pkg.sv
// Purpose: Shared constants for the radio FIFO packet path
// Assumes: 50 MHz core clock, SPI clock supplied by the host
// Notes: Timing counts derive from times in ns
package rfpp_pkg;
  localparam logic [7:0] CMD_TX_WRITE = 8'h66;
  localparam logic [7:0] CMD_RX_READ = 8'h77;
  localparam int FIFO_AW = 6;
  localparam int CORE_MHZ = 50;
  localparam int BIT_NS = 640;
  localparam int BIT_CYC = BIT_NS * CORE_MHZ / 1000;
  localparam int DGL_NS = 60;
  localparam int DGL_CYC = (DGL_NS * CORE_MHZ + 999) / 1000;
  localparam int LOCK_TRANS = 4;
  localparam logic [7:0] PRE_BYTE = 8'hAA;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [8:0] PRBS_SEED = 9'h1FF;
  localparam logic [1:0] IDLE_RST = 2'h1;
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_TX = 2'h1;
  localparam logic [1:0] MODE_RX = 2'h2;
  localparam logic [1:0] MODE_DIRECT = 2'h3;
  localparam logic [1:0] SRC_FIFO = 2'h0;
  localparam logic [1:0] SRC_PRBS = 2'h1;
  localparam logic [1:0] SRC_CW = 2'h2;

  typedef enum {
    ST_IDLE, ST_TX_PRE, ST_TX_SYNC, ST_TX_LEN, ST_TX_DATA, ST_TX_CRC,
    ST_RX_HUNT, ST_RX_DATA
  } rfpp_state_e;

  // Bitwise CRC over one byte, MSB first
  function automatic logic [15:0] rfpp_crc_byte(input logic [15:0] c,
                                                input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (r[15] ^ b[i])
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      else
        r = {r[14:0], 1'b0};
    end
    return r;
  endfunction : rfpp_crc_byte
endpackage : rfpp_pkg

// >>> rtl/rfpp_mem.sv
// Purpose: 64 x 8 FIFO storage with registered read data
// Assumes: One write and one read port on the core clock
// Notes: Read data follow the address one cycle later
`timescale 1ns/1ns
module rfpp_mem (
  // Clock
  input wire logic i_clk,
  input wire logic i_ce,
  // Write port
  input wire logic i_we,
  input wire logic [rfpp_pkg::FIFO_AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // Read port
  input wire logic [rfpp_pkg::FIFO_AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:(1 << rfpp_pkg::FIFO_AW)-1];

  always_ff @(posedge i_clk)
  begin
    if (i_ce && i_we)
      mem[i_waddr] <= i_wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_ce)
      o_rdata <= mem[i_raddr];
  end
endmodule : rfpp_mem

// >>> testbench/rfpp_checker.sv
// Purpose: Port assertions for the FIFO packet path
// Assumes: Idle select held steady during packets
// Notes: Watches a subset of top ports
`timescale 1ns/1ns
module rfpp_checker (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Inputs
  input wire logic i_spi_cs_n,
  input wire logic [1:0] i_idle_sel,
  input wire logic [1:0] i_irq_en,
  input wire logic i_status_rd,
  // Outputs
  input wire logic o_spi_sdo_oe,
  input wire logic o_rx_clk,
  input wire logic [1:0] o_mode,
  input wire logic [1:0] o_idle_state,
  input wire logic o_tx_done_event,
  input wire logic o_rx_done_event,
  input wire logic [1:0] o_int_status,
  input wire logic o_radio_irq_n,
  input wire logic [6:0] o_tx_level,
  input wire logic [6:0] o_rx_level
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_sdo_enable: assert property (o_spi_sdo_oe == !i_spi_cs_n)
    else $error("sdo enable wrong");
  a_tx_exit: assert property (o_tx_done_event |-> ##[0:2] o_mode == 2'h0)
    else $error("tx not left");
  a_rx_exit: assert property (o_rx_done_event |-> ##[0:2] o_mode == 2'h0)
    else $error("rx not left");
  a_idle_load: assert property ((o_tx_done_event || o_rx_done_event)
    |-> ##[0:2] o_idle_state == i_idle_sel)
    else $error("idle state wrong");
  a_irq_set: assert property (o_tx_done_event && i_irq_en[0]
    |=> o_int_status[0])
    else $error("irq not set");
  a_irq_hold: assert property (o_int_status[1] && !i_status_rd
    |=> o_int_status[1])
    else $error("irq dropped");
  a_irq_pin: assert property (o_radio_irq_n == !(|o_int_status))
    else $error("irq pin wrong");
  a_rx_strobe: assert property (o_rx_clk |=> !o_rx_clk [*8])
    else $error("rx clock too fast");
  a_fifo_cap: assert property (o_tx_level <= 7'h40 && o_rx_level <= 7'h40)
    else $error("level over depth");
  c_tx: cover property (o_tx_done_event);
  c_rx: cover property (o_rx_done_event);
  c_irq: cover property (!o_radio_irq_n);
endmodule : rfpp_checker

// >>> testbench/rfpp_host.sv
// Purpose: Host SPI master model, mode 0
// Assumes: 160 ns bit period, sck low outside frames
// Notes: One command plus data bytes per frame
`timescale 1ns/1ns
module rfpp_host (
  // SPI pins
  output logic o_sck,
  output logic o_cs_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  initial
  begin
    o_sck = 0;
    o_cs_n = 1;
    o_sdi = 0;
  end
  // Command then data in one select
  task automatic xfer(input logic [7:0] cmd, ref logic [7:0] d [$]);
    logic [7:0] b;
    b = cmd;
    #7 o_cs_n = 0;
    for (int k = 0; k <= d.size(); k++)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        o_sdi = b[i];
        #80 o_sck = 1;
        b[i] = i_sdo;
        #80 o_sck = 0;
      end
      if (k > 0)
        d[k - 1] = b;
      if (k < d.size())
        b = d[k];
    end
    #80 o_cs_n = 1;
    // Released line must not look like fresh data
    o_sdi = ~o_sdi;
    #160;
  endtask : xfer
endmodule : rfpp_host

// >>> testbench/test_radio_fifo_packet_path.sv
// Purpose: Self-checking bench for the FIFO packet path
// Assumes: Sync and async demodulator, alternating preamble
// Notes: Queues hold the expected bytes
`timescale 1ns/1ns
module test_radio_fifo_packet_path;
  logic i_core_clk = 0, i_rst_n = 0, i_ce = 1, i_ph_en = 0;
  logic i_direct_mode = 0, i_async_demod = 0, i_direct_tx_bit = 0;
  logic i_start_tx = 0, i_start_rx = 0, i_status_rd = 0, i_demod_raw = 0;
  logic [1:0] i_idle_sel = 0, i_tx_src = 0, i_irq_en = 2'h3;
  logic [6:0] i_pkt_len = 7'h04;
  logic [3:0] i_pre_bytes = 4'h1;
  logic [15:0] i_sync_word = 16'h2DD4;
  logic [4:0] i_pre_thresh = 5'h10;
  wire i_spi_sck, i_spi_cs_n, i_spi_sdi, o_spi_sdo, o_spi_sdo_oe;
  wire o_tx_bit, o_cw_en, o_rx_bit_tap, o_rx_clk, o_bcr_lock, o_crc_err;
  wire o_tx_done_event, o_rx_done_event, o_radio_irq_n;
  wire [1:0] o_mode, o_idle_state, o_int_status;
  wire [7:0] o_freq_err;
  wire [6:0] o_tx_level, o_rx_level;
  logic [7:0] q [$], w [$], b, e;
  logic [15:0] c;
  logic [8:0] r = rfpp_pkg::PRBS_SEED;
  int failures = 0, n_tests = 0, seed = 32'ha007, n_ev = 0, ev_exp = 0;
  rfpp_top DUT (.*);
  rfpp_host host (.o_sck(i_spi_sck), .o_cs_n(i_spi_cs_n),
    .o_sdi(i_spi_sdi), .i_sdo(o_spi_sdo));
  always #10 i_core_clk = ~i_core_clk;
  // Done pulses are short, so count them as they pass
  always @(posedge i_core_clk)
    n_ev <= n_ev + (o_tx_done_event | o_rx_done_event);
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [15:0] crc(input logic [15:0] c,
                                      input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? rfpp_pkg::CRC_POLY : 16'h0);
    return c;
  endfunction : crc
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : tick
  task automatic rx_bits(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
    begin
      i_demod_raw <= v[i];
      tick(32);
      chk("tap", v[i], o_rx_bit_tap);
    end
  endtask : rx_bits
  task automatic wait_ev;
    ev_exp++;
    for (int k = 0; n_ev < ev_exp && k < 900; k++)
      tick(1);
    chk("done", 8'(ev_exp), 8'(n_ev));
    tick(3);
    chk("mode", rfpp_pkg::MODE_IDLE, o_mode);
    chk("idle", i_idle_sel, o_idle_state);
    chk("irq_n", 8'h00, o_radio_irq_n);
    i_status_rd <= 1;
    tick(1);
    i_status_rd <= 0;
    tick(2);
    chk("irq_n", 8'h01, o_radio_irq_n);
  endtask : wait_ev
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  initial
  begin
    #600000;
    failures++;
    stop_test();
  end
  initial
  begin
    tick(2);
    i_rst_n <= 1;
    tick(4);
    chk("irq_n", 8'h01, o_radio_irq_n);
    chk("idle", 8'h01, o_idle_state);
    for (int p = 0; p < 4; p++)
    begin
      w = {};
      for (int i = 0; i < 3 + p; i++)
        w.push_back(8'($random(seed)));
      q = {};
      if (p == 1)
        q = {8'hAA, 8'hAA, i_sync_word[15:8], i_sync_word[7:0], 8'h04};
      // CW sends a flat zero line; PRBS bytes come from the bench LFSR
      foreach (w[i]) q.push_back(p == 2 ? 8'h00 : w[i]);
      c = rfpp_pkg::CRC_INIT;
      for (int i = 4; i < q.size(); i++)
        c = crc(c, q[i]);
      if (p == 1)
        q = {q, c[15:8], c[7:0]};
      i_ph_en <= p == 1;
      i_tx_src <= p == 2 ? rfpp_pkg::SRC_CW :
                  p == 3 ? rfpp_pkg::SRC_PRBS : rfpp_pkg::SRC_FIFO;
      i_pkt_len <= 7'(3 + p);
      i_pre_bytes <= 4'(1 + p);
      i_idle_sel <= 2'($random(seed));
      host.xfer(rfpp_pkg::CMD_TX_WRITE, w);
      tick(20);
      chk("tx_level", 8'(3 + p), o_tx_level);
      i_start_tx <= 1;
      tick(1);
      i_start_tx <= 0;
      for (int n = 0; q.size() > 0; n++)
      begin
        tick(n ? 32 : 16);
        #1 b = {b[6:0], o_tx_bit};
        e = {e[6:0], r[8]};
        r = {r[7:0], r[8] ^ r[4]};
        if (n % 8 == 7)
        begin
          chk("cw_en", 8'(p == 2), o_cw_en);
          chk("tx_byte", p == 3 ? e : q[0], b);
          q.delete(0);
        end
      end
      wait_ev();
      $display("test tx ph %0d over", p);
    end
    for (int p = 0; p < 3; p++)
    begin
      i_ph_en <= p == 1;
      i_async_demod <= p == 2;
      i_pkt_len <= 7'h04;
      i_idle_sel <= 2'($random(seed));
      i_start_rx <= 1;
      tick(1);
      i_start_rx <= 0;
      q = {};
      repeat (4) rx_bits(8'hAA);
      chk("lock", 8'h01, o_bcr_lock);
      chk("ferr", 8'h00, o_freq_err);
      rx_bits(i_sync_word[15:8]);
      rx_bits(i_sync_word[7:0]);
      c = crc(rfpp_pkg::CRC_INIT, 8'h04);
      if (p == 1)
        rx_bits(8'h04);
      repeat (4)
      begin
        b = 8'($random(seed));
        q.push_back(b);
        c = crc(c, b);
        rx_bits(b);
      end
      // CRC bytes trail the payload and must stay out
      if (p == 1)
      begin
        rx_bits(c[15:8]);
        rx_bits(c[7:0]);
      end
      wait_ev();
      chk("rx_level", 8'h04, o_rx_level);
      chk("crc_err", 8'h00, o_crc_err);
      w = {};
      repeat (5) w.push_back(8'h00);
      q.push_back(8'h00);
      host.xfer(rfpp_pkg::CMD_RX_READ, w);
      foreach (w[i]) chk("rx_byte", q[i], w[i]);
      $display("test rx ph %0d over", p);
    end
    i_direct_mode <= 1;
    i_direct_tx_bit <= 1;
    tick(4);
    chk("direct", 8'h01, o_tx_bit);
    chk("mode", rfpp_pkg::MODE_DIRECT, o_mode);
    $display("test direct over");
    stop_test();
  end
endmodule : test_radio_fifo_packet_path
bind rfpp_top rfpp_checker u_chk (.i_core_clk, .i_rst_n, .i_spi_cs_n,
  .i_idle_sel, .i_irq_en, .i_status_rd, .o_spi_sdo_oe, .o_rx_clk, .o_mode,
  .o_idle_state, .o_tx_done_event, .o_rx_done_event, .o_int_status,
  .o_radio_irq_n, .o_tx_level, .o_rx_level);
